// ---- core/icc_cfg.svh ----
`ifndef ICC_CFG_SVH
`define ICC_CFG_SVH

// Register byte addresses.
`define ICC_ADDR_CTRL     8'h00
`define ICC_ADDR_STAT     8'h04
`define ICC_ADDR_BUF      8'h08
`define ICC_ADDR_IRQSTAT  8'h0C
`define ICC_ADDR_IRQMASK  8'h10

// Control field positions.
`define ICC_CTRL_EN       0
`define ICC_CTRL_MODE_LO  1
`define ICC_CTRL_MODE_HI  3
`define ICC_CTRL_TSEL_LO  4
`define ICC_CTRL_TSEL_HI  5
`define ICC_CTRL_FIRST    6
`define ICC_CTRL_LVL_LO   7
`define ICC_CTRL_LVL_HI   8
`define ICC_CTRL_WAKE     9
`define ICC_CTRL_W        10

// Status and interrupt bit positions.
`define ICC_STAT_NEMPTY   0
`define ICC_STAT_OVF      1
`define ICC_STAT_CNT_LO   2
`define ICC_STAT_CNT_HI   4
`define ICC_IRQ_LEVEL     0
`define ICC_IRQ_EDGE      1
`define ICC_IRQ_OVF       2
`define ICC_IRQ_W         3

// Reset values and prescaler counts.
`define ICC_CTRL_RST      10'h000
`define ICC_MASK_RST      3'h0
`define ICC_DIV4          5'h04
`define ICC_DIV16         5'h10

`endif

// ---- core/icc_fifo.sv ----
`timescale 1ns/1ps

module icc_fifo
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4,
   parameter int CNTW  = 3
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Buffer port.
   icc_fifo_if.owner f
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr;
   logic [PW-1:0]    rdPtr;
   logic [CNTW-1:0]  count;
   logic             doPush;
   logic             doPop;

   assign doPush     = f.push && (count != CNTW'(DEPTH));
   assign doPop      = f.pop && (count != '0);
   assign f.headData = mem[rdPtr];
   assign f.count    = count;
   assign f.full     = (count == CNTW'(DEPTH));
   assign f.empty    = (count == '0);

   always_ff @(posedge clk)
   begin
      if (doPush)
         mem[wrPtr] <= f.pushData;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end
      else
      begin
         if (doPush)
            wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         if (doPop)
            rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         if (doPush && !doPop)
            count <= count + 1'b1;
         else if (doPop && !doPush)
            count <= count - 1'b1;
      end
   end
endmodule

// ---- core/icc_fifo_if.sv ----
`timescale 1ns/1ps

interface icc_fifo_if #(parameter int WIDTH = 32, parameter int CNTW = 3);
   logic             push;
   logic [WIDTH-1:0] pushData;
   logic             pop;
   logic [WIDTH-1:0] headData;
   logic [CNTW-1:0]  count;
   logic             full;
   logic             empty;

   modport owner (input push, input pushData, input pop, output headData, output count, output full, output empty);
   modport user  (output push, output pushData, output pop, input headData, input count, input full, input empty);
endinterface

// ---- core/icc_pkg.sv ----
package icc_pkg;

   typedef enum logic [2:0]
   {
      ICC_OFF,
      ICC_FALL,
      ICC_RISE,
      ICC_EVERY,
      ICC_EVERY_FIRST,
      ICC_DIV4_RISE,
      ICC_DIV16_RISE,
      ICC_RSVD
   } icc_mode_e;

   typedef enum logic [1:0]
   {
      ICC_TB_FIRST,
      ICC_TB_SECOND,
      ICC_TB_CASCADE,
      ICC_TB_RSVD
   } icc_tsel_e;

endpackage

// ---- core/input_capture_channel.sv ----
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "icc_cfg.svh"

// How it works
// (RQ1) Qualifying event latches selected time base count.
// (RQ2) Falling mode captures every high-to-low edge.
// (RQ3) Rising mode captures every low-to-high edge.
// (RQ4) Every-edge mode captures both edge polarities.
// (RQ5) Every-edge mode with software-chosen first edge.
// (RQ6) Divide-by-four captures every fourth rising edge.
// (RQ7) Divide-by-sixteen captures every sixteenth rising edge.
// (RQ8) Select one of two 16-bit timers.
// (RQ9) Cascade mode captures joined 32-bit count.
// (RQ10) Timer clock source internal or external works.
// (RQ11) Pin event wakes device from Sleep/Idle.
// (RQ12) Capture events can raise an interrupt.
// (RQ13) Four-entry first-in first-out capture buffer.
// (RQ14) Interrupt after one to four entries.
// (RQ15) Pin edges serve as external interrupt.
// (RQ16) Buffer reads oldest first, pop, not-empty status.
// (RQ17) Synchronise input; full buffer sets overflow flag.
module input_capture_channel
   import icc_pkg::*;
#(
   parameter int TW    = 16,
   parameter int DEPTH = 4
)
(
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Wishbone slave.
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   output logic               wb_err_o,
   // Pin and time bases.
   input  wire logic          capture_input_pin,
   input  wire logic [TW-1:0] first_time_base_timer,
   input  wire logic [TW-1:0] second_time_base_timer,
   input  wire logic          lowPowerState,
   // Events out.
   output logic               irq,
   output logic               wakeReq
);
   localparam int CW = 2 * TW;
   localparam int NW = $clog2(DEPTH + 1);

   // Each register takes one word of the map. CTRL at 0x00 holds enable, mode,
   // time base select, first-edge polarity, interrupt level and wake enable.
   // STAT at 0x04 is read only and shows not-empty, overflow and the entry count.
   // BUF at 0x08 pops the oldest capture on every read; an empty buffer reads zero.
   // IRQSTAT at 0x0C is write-one-to-clear and IRQMASK at 0x10 shares its layout.
   // A hardware set always beats a software clear in the same cycle, so no event
   // is lost while software acknowledges an older one.

   //**********************************************************************
   // Control registers
   //**********************************************************************
   logic [`ICC_CTRL_W-1:0] ctrl;
   logic [`ICC_IRQ_W-1:0]  irqStat;
   logic [`ICC_IRQ_W-1:0]  irqMask;
   logic                   ovf;
   icc_mode_e              mode;
   icc_tsel_e              tsel;
   logic [1:0]             lvl;
   logic                   enable;

   // Every mode and time base code is decoded, so the casts below never leave
   // their enums. The reserved mode behaves as off and the reserved time base
   // select behaves as cascade.
   assign enable = ctrl[`ICC_CTRL_EN];
   assign mode   = icc_mode_e'(ctrl[`ICC_CTRL_MODE_HI:`ICC_CTRL_MODE_LO]);
   assign tsel   = icc_tsel_e'(ctrl[`ICC_CTRL_TSEL_HI:`ICC_CTRL_TSEL_LO]);
   assign lvl    = ctrl[`ICC_CTRL_LVL_HI:`ICC_CTRL_LVL_LO];

   // Byte-lane write merge for the low half of a register.
   function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      laneMerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   //**********************************************************************
   // Bus decode
   //**********************************************************************
   logic req;
   logic wrCtrl;
   logic wrIrqStat;
   logic wrMask;
   logic rdBuf;
   logic mapped;
   logic [15:0] wrWord;

   // Every access is answered on the edge after it is taken, and the answer
   // itself blocks a second take, so a master holding its strobe sees exactly
   // one access per acknowledge. Unmapped addresses get an error and change
   // nothing.
   assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign mapped    = (wb_adr_i == `ICC_ADDR_CTRL) || (wb_adr_i == `ICC_ADDR_STAT) || (wb_adr_i == `ICC_ADDR_BUF)
                      || (wb_adr_i == `ICC_ADDR_IRQSTAT) || (wb_adr_i == `ICC_ADDR_IRQMASK);
   assign wrCtrl    = req && wb_we_i && (wb_adr_i == `ICC_ADDR_CTRL);
   assign wrIrqStat = req && wb_we_i && (wb_adr_i == `ICC_ADDR_IRQSTAT) && wb_sel_i[0];
   assign wrMask    = req && wb_we_i && (wb_adr_i == `ICC_ADDR_IRQMASK) && wb_sel_i[0];
   assign rdBuf     = req && !wb_we_i && (wb_adr_i == `ICC_ADDR_BUF);
   assign wrWord    = laneMerge({6'h00, ctrl}, wb_dat_i, wb_sel_i);

   //**********************************************************************
   // Input synchroniser and edge detection
   //**********************************************************************
   logic pinMeta;
   logic pinSync;
   logic pinLast;
   logic riseEdge;
   logic fallEdge;
   logic anyEdge;

   // Two flops guard against metastability on the asynchronous pin; the third
   // holds the previous settled level for edge detection. Every flop resets low,
   // which matches the idle level of the pin, so no false edge follows reset.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
         pinLast <= 1'b0;
      end
      else
      begin
         pinMeta <= capture_input_pin; // RQ17
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   assign riseEdge = pinSync && !pinLast;
   assign fallEdge = !pinSync && pinLast;
   assign anyEdge  = riseEdge || fallEdge;

   //**********************************************************************
   // Event qualification
   //**********************************************************************
   // The first-edge gate re-arms on every mode write so software can restart
   // a pulse measurement with a known polarity.
   logic       firstSeen;
   logic [4:0] preCnt;
   logic [4:0] preDiv;
   logic       capEvent;

   // True for the two modes that count rising edges before capturing.
   function automatic logic isPrescaled(input icc_mode_e m);
      isPrescaled = (m == ICC_DIV4_RISE) || (m == ICC_DIV16_RISE);
   endfunction

   // The prescaler counts rising edges only while a prescaled mode is active.
   // It restarts from zero on every control write, so the first capture after
   // a mode change comes on the fourth or sixteenth edge seen after that write.
   assign preDiv = (mode == ICC_DIV16_RISE) ? `ICC_DIV16 : `ICC_DIV4;

   always_comb
   begin
      capEvent = 1'b0;
      unique case (mode)
         ICC_FALL:        capEvent = fallEdge; // RQ2
         ICC_RISE:        capEvent = riseEdge; // RQ3
         ICC_EVERY:       capEvent = anyEdge; // RQ4
         ICC_EVERY_FIRST: capEvent = firstSeen ? anyEdge
                                     : (ctrl[`ICC_CTRL_FIRST] ? riseEdge : fallEdge); // RQ5
         ICC_DIV4_RISE,
         ICC_DIV16_RISE:  capEvent = riseEdge && (preCnt == preDiv - 5'h01); // RQ6 RQ7
         ICC_OFF,
         ICC_RSVD:        capEvent = 1'b0;
      endcase
      capEvent = capEvent && enable;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         firstSeen <= 1'b0;
      else if (wrCtrl || !enable)
         firstSeen <= 1'b0;
      else if (mode == ICC_EVERY_FIRST && capEvent)
         firstSeen <= 1'b1; // RQ5
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         preCnt <= 5'h00;
      else if (wrCtrl || !enable)
         preCnt <= 5'h00;
      else if (riseEdge && isPrescaled(mode))
         preCnt <= capEvent ? 5'h00 : preCnt + 5'h01; // RQ6 RQ7
   end

   //**********************************************************************
   // Time base selection and capture buffer
   //**********************************************************************
   // Timers arrive as counts in this clock domain, so their own clock source
   // (internal or external) does not matter here.
   logic [CW-1:0] stamp;

   always_comb
   begin
      unique case (tsel)
         ICC_TB_FIRST:   stamp = {{TW{1'b0}}, first_time_base_timer}; // RQ8 RQ10
         ICC_TB_SECOND:  stamp = {{TW{1'b0}}, second_time_base_timer}; // RQ8
         ICC_TB_CASCADE,
         ICC_TB_RSVD:    stamp = {second_time_base_timer, first_time_base_timer}; // RQ9
      endcase
   end

   // The buffer stores full 32-bit stamps even for a 16-bit time base, so a
   // switch to cascade mode never needs a second layout. Its count is one bit
   // wider than the pointers so that full and empty stay distinct and the
   // count can be shown directly in the status register.
   icc_fifo_if #(.WIDTH(CW), .CNTW(NW)) fif ();

   assign fif.push     = capEvent; // RQ1
   assign fif.pushData = stamp;
   assign fif.pop      = rdBuf; // RQ16

   icc_fifo #(.WIDTH(CW), .DEPTH(DEPTH), .CNTW(NW)) u_fifo
   (
      .clk   (clk),
      .rst_n (rst_n),
      .f     (fif.owner)
   ); // RQ13

   // A capture that meets a full buffer is dropped, never written over the
   // oldest entry, and the overflow flag records the loss until software
   // clears it through the interrupt status register. The set wins over a
   // clear in the same cycle.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ovf <= 1'b0;
      else if (capEvent && fif.full)
         ovf <= 1'b1; // RQ17
      else if (wrIrqStat && wb_dat_i[`ICC_IRQ_OVF])
         ovf <= 1'b0;
   end

   //**********************************************************************
   // Interrupt status
   //**********************************************************************
   logic [`ICC_IRQ_W-1:0] irqSet;
   logic                  levelHit;

   // The level bit fires when a push brings the entry count to the programmed
   // level plus one. The edge bit turns every pin edge into an external
   // interrupt source while the channel is enabled, whatever the capture mode
   // is, so the pin can be used for interrupts alone.
   assign levelHit = capEvent && !fif.full && (fif.count == NW'(lvl)); // RQ14
   assign irqSet   = {capEvent && fif.full, enable && anyEdge, levelHit}; // RQ12 RQ15

   // Ones written clear their bits, but an event in the same cycle sets its
   // bit again, so software never loses an event while acknowledging.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqStat <= '0;
      else if (wrIrqStat)
         irqStat <= (irqStat & ~wb_dat_i[`ICC_IRQ_W-1:0]) | irqSet;
      else
         irqStat <= irqStat | irqSet;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irqMask <= `ICC_MASK_RST;
      else if (wrMask)
         irqMask <= wb_dat_i[`ICC_IRQ_W-1:0];
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl <= `ICC_CTRL_RST;
      else if (wrCtrl)
         ctrl <= wrWord[`ICC_CTRL_W-1:0];
   end

   // Both event outputs are registered so they come straight from flops, at
   // the cost of one cycle of latency. The wake request is a single-cycle
   // pulse; the power controller has to latch it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq     <= 1'b0;
         wakeReq <= 1'b0;
      end
      else
      begin
         irq     <= |(irqStat & irqMask); // RQ12
         wakeReq <= ctrl[`ICC_CTRL_WAKE] && lowPowerState && enable && anyEdge; // RQ11
      end
   end

   //**********************************************************************
   // Bus answer
   //**********************************************************************
   // Read data is driven only together with the acknowledge and is zero at all
   // other times, so a shared read bus can simply OR the slaves together.
   logic [31:0] rdData;

   always_comb
   begin
      rdData = 32'h0000_0000;
      unique case (wb_adr_i)
         `ICC_ADDR_CTRL:    rdData[`ICC_CTRL_W-1:0] = ctrl;
         `ICC_ADDR_STAT:    rdData[`ICC_STAT_CNT_HI:0] = {fif.count, ovf, !fif.empty}; // RQ16
         `ICC_ADDR_BUF:     rdData = fif.empty ? 32'h0000_0000 : 32'(fif.headData);
         `ICC_ADDR_IRQSTAT: rdData[`ICC_IRQ_W-1:0] = irqStat;
         `ICC_ADDR_IRQMASK: rdData[`ICC_IRQ_W-1:0] = irqMask;
         default:           rdData = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req && mapped;
         wb_err_o <= req && !mapped;
         wb_dat_o <= (req && mapped && !wb_we_i) ? rdData : 32'h0000_0000;
      end
   end
endmodule

// ---- test/icc_pin_src.sv ----
`timescale 1ns/1ps
// *****
// Capture pin source.
// *****
module icc_pin_src
(
   // Clock.
   input wire logic clk,
   // Driven pin.
   output logic     pin
);
   initial pin = 1'b0;
   // Each level stands seven clocks so the three-flop synchroniser never misses one.
   task automatic drive(input logic v);
      @(posedge clk);
      pin <= v;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ---- test/input_capture_channel_chk.sv ----
`timescale 1ns/1ps
`include "icc_cfg.svh"
module input_capture_channel_chk
#(
   parameter int TW    = 16,
   parameter int DEPTH = 4
)
(
   // Clock and reset.
   input wire logic          clk,
   input wire logic          rst_n,
   // Bus.
   input wire logic          wb_cyc_i,
   input wire logic          wb_stb_i,
   input wire logic          wb_we_i,
   input wire logic [7:0]    wb_adr_i,
   input wire logic [3:0]    wb_sel_i,
   input wire logic [31:0]   wb_dat_i,
   input wire logic [31:0]   wb_dat_o,
   input wire logic          wb_ack_o,
   input wire logic          wb_err_o,
   // Pin, time bases and events.
   input wire logic          capture_input_pin,
   input wire logic [TW-1:0] first_time_base_timer,
   input wire logic [TW-1:0] second_time_base_timer,
   input wire logic          lowPowerState,
   input wire logic          irq,
   input wire logic          wakeReq
);
   // *****
   // Checks.
   // *****
   wire logic mapped = wb_adr_i inside {`ICC_ADDR_CTRL, `ICC_ADDR_STAT, `ICC_ADDR_BUF, `ICC_ADDR_IRQSTAT, `ICC_ADDR_IRQMASK};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   endsequence
   sequence s_mask_off;
      s_take ##0 (wb_we_i && wb_adr_i == `ICC_ADDR_IRQMASK && wb_sel_i[0] && wb_dat_i[2:0] == 3'h0);
   endsequence
   a_answer_next: assert property (s_take |=> wb_ack_o || wb_err_o)
      else $error("request not answered on the next edge");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_err_unmapped: assert property (s_take ##0 !mapped |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (s_take ##0 mapped |=> !wb_err_o)
      else $error("mapped access refused");
   a_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
      else $error("answer without request");
   a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   a_mask_quiet: assert property (s_mask_off |-> ##3 !irq)
      else $error("irq high with all sources masked");
   a_wake_awake: assert property ((!lowPowerState)[*5] |-> !wakeReq)
      else $error("wake request while awake");
   a_wake_pulse: assert property (wakeReq |=> !wakeReq)
      else $error("wake request longer than one cycle");
endmodule

// ---- test/test_input_capture_channel.sv ----
`timescale 1ns/1ps
`include "icc_cfg.svh"
module test_input_capture_channel import icc_pkg::*; ();
   localparam int TW    = 16;
   localparam int DEPTH = 4;
   logic        clk                    = 1'b0;
   logic        rst_n                  = 1'b0;
   logic        wb_cyc_i               = 1'b0;
   logic        wb_stb_i               = 1'b0;
   logic        wb_we_i                = 1'b0;
   logic [7:0]  wb_adr_i               = 8'h00;
   logic [3:0]  wb_sel_i               = 4'hF;
   logic [31:0] wb_dat_i               = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        wb_err_o;
   wire logic   capture_input_pin;
   logic [15:0] first_time_base_timer  = 16'h0000;
   logic [15:0] second_time_base_timer = 16'h0000;
   logic        lowPowerState          = 1'b0;
   logic        irq;
   logic        wakeReq;
   logic [31:0] rdat;
   logic        rerr;
   int          fails                  = 0;
   int          cmp_count              = 0;
   int          wakes                  = 0;
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   input_capture_channel #(.TW(TW), .DEPTH(DEPTH)) dut_u (.*);
   icc_pin_src src (.clk(clk), .pin(capture_input_pin));
   always @(posedge clk)
   begin
      if (wakeReq === 1'b1)
         wakes <= wakes + 1;
   end
   // *****
   // Helpers.
   // *****
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 64);
      rdat = wb_dat_o;
      rerr = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 64)
      begin
         chk(32'h0, 32'h1);
         tally_and_finish();
      end
   endtask
   function automatic logic [31:0] ctl(input icc_mode_e m, input logic [1:0] t, input logic f,
                                       input logic [1:0] l, input logic w);
      return {22'h000000, w, l, f, t, m, 1'b1};
   endfunction
   task automatic pulses(input int n);
      repeat (n)
      begin
         src.drive(1'b1);
         src.drive(1'b0);
      end
   endtask
   // Disabling first also restarts the prescaler and the first-edge gate.
   task automatic drain();
      wb(1'b1, `ICC_ADDR_CTRL, 32'h0);
      repeat (DEPTH) wb(1'b0, `ICC_ADDR_BUF, 32'h0);
      wb(1'b1, `ICC_ADDR_IRQSTAT, 32'h7);
   endtask
   // *****
   // Scenarios.
   // *****
   task automatic s_reset();
      wb(1'b0, `ICC_ADDR_STAT, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, `ICC_ADDR_IRQMASK, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b1, 8'h14, 32'h0);
      chk(rerr, 1'b1);
   endtask
   task automatic s_modes();
      icc_mode_e m [9] = '{ICC_FALL, ICC_RISE, ICC_EVERY, ICC_EVERY_FIRST, ICC_EVERY_FIRST,
                           ICC_DIV4_RISE, ICC_DIV16_RISE, ICC_OFF, ICC_RSVD};
      logic      f [9] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      int        p [9] = '{2, 2, 1, 1, 1, 7, 31, 2, 2};
      int        c [9] = '{2, 2, 2, 2, 1, 1, 1, 0, 0};
      for (int i = 0; i < 9; i++)
      begin
         drain();
         wb(1'b1, `ICC_ADDR_CTRL, ctl(m[i], 2'h0, f[i], 2'h0, 1'b0));
         pulses(p[i]);
         wb(1'b0, `ICC_ADDR_STAT, 32'h0);
         chk(rdat[4:2], c[i]);
         chk(rdat[0], c[i] != 0);
      end
   endtask
   task automatic s_stamps();
      logic [15:0] a;
      logic [15:0] b;
      for (int t = 0; t < 4; t++)
      begin
         drain();
         wb(1'b1, `ICC_ADDR_CTRL, ctl(ICC_RISE, 2'(t), 1'b0, 2'h0, 1'b0));
         for (int k = 1; k < 3; k++)
         begin
            first_time_base_timer  <= 16'(16'h0110 * k);
            second_time_base_timer <= 16'(16'hAB00 + k);
            pulses(1);
         end
         for (int k = 1; k < 3; k++)
         begin
            a = 16'(16'h0110 * k);
            b = 16'(16'hAB00 + k);
            wb(1'b0, `ICC_ADDR_BUF, 32'h0);
            chk(rdat, t == 0 ? {16'h0000, a} : t == 1 ? {16'h0000, b} : {b, a});
         end
      end
   endtask
   task automatic s_levels();
      first_time_base_timer <= 16'h0001;
      for (int l = 0; l < 4; l++)
      begin
         drain();
         wb(1'b1, `ICC_ADDR_IRQMASK, 32'h1);
         wb(1'b1, `ICC_ADDR_CTRL, ctl(ICC_RISE, 2'h0, 1'b0, 2'(l), 1'b0));
         pulses(l);
         chk(irq, 1'b0);
         pulses(1);
         chk(irq, 1'b1);
      end
      first_time_base_timer <= 16'h0EEE;
      pulses(1);
      wb(1'b0, `ICC_ADDR_STAT, 32'h0);
      chk(rdat, 32'h13);
      repeat (DEPTH) wb(1'b0, `ICC_ADDR_BUF, 32'h0);
      chk(rdat, 32'h1);
      wb(1'b1, `ICC_ADDR_IRQSTAT, 32'h7);
      wb(1'b0, `ICC_ADDR_STAT, 32'h0);
      chk(rdat, 32'h0);
      chk(irq, 1'b0);
   endtask
   task automatic s_extint();
      drain();
      wb(1'b1, `ICC_ADDR_IRQMASK, 32'h2);
      wb(1'b1, `ICC_ADDR_CTRL, ctl(ICC_FALL, 2'h0, 1'b0, 2'h0, 1'b0));
      pulses(1);
      chk(irq, 1'b1);
      wb(1'b1, `ICC_ADDR_IRQSTAT, 32'h2);
      wb(1'b0, `ICC_ADDR_IRQSTAT, 32'h0);
      chk(rdat, 32'h1);
      chk(irq, 1'b0);
      wb(1'b1, `ICC_ADDR_IRQMASK, 32'h0);
      pulses(1);
      chk(irq, 1'b0);
      wb(1'b0, `ICC_ADDR_IRQSTAT, 32'h0);
      chk(rdat[1], 1'b1);
   endtask
   task automatic s_wake();
      int w0;
      for (int s = 0; s < 3; s++)
      begin
         drain();
         lowPowerState <= (s != 1);
         wb(1'b1, `ICC_ADDR_CTRL, ctl(ICC_RISE, 2'h0, 1'b0, 2'h0, s != 2));
         w0 = wakes;
         pulses(1);
         chk(wakes != w0, s == 0);
      end
      lowPowerState <= 1'b0;
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      s_reset();
      s_modes();
      s_stamps();
      s_levels();
      s_extint();
      s_wake();
      tally_and_finish();
   end
endmodule
bind input_capture_channel input_capture_channel_chk #(.TW(TW), .DEPTH(DEPTH)) chk_u (.*);
